// ===== logic/wdslp_top.sv
// watchdog timer with shared scaler, sleep entry and wake-up control, apb slave
// the watchdog count runs on the system clock here; the nominal period and clock rate only set how
// many clocks make one period, so the period parameter is the single knob
// a kick and a time-out in one cycle: the kick wins, no reset is raised
// the pin reset is three flops late; a glitch that covers no rising clock edge is lost
// apb writes land on the edge that completes the transfer, not the edge before
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module wdslp_top #(
   parameter int PERIOD_CYC = wdslp_pkg::PERIOD_CYC, // long count, shortenable
   parameter int N_PORT = 16 // io pins held during sleep
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [17:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // external reset pin (asynchronous, active low, synchronised here)
   input wire logic i_external_reset_pin_n,
   // core side: instruction events, global enable, program counter
   input wire logic i_kick_instruction,
   input wire logic i_sleep_instruction,
   input wire logic i_global_irq_enable,
   input wire logic [15:0] i_pc,
   // wake-capable interrupt flags and their enables
   input wire logic [wdslp_pkg::N_WAKE-1:0] i_wake_irq_flag,
   input wire logic [wdslp_pkg::N_WAKE-1:0] i_wake_irq_en,
   // core io drive state
   input wire logic [N_PORT-1:0] i_port_out,
   input wire logic [N_PORT-1:0] i_port_oe,
   // outputs to the device
   output logic o_device_reset,
   output logic o_sleeping,
   output logic o_main_osc_en,
   output logic o_rc_osc_en,
   output logic o_vector_irq,
   output logic [15:0] o_prefetch_addr,
   output logic [15:0] o_vector_addr,
   output logic [N_PORT-1:0] o_port_out,
   output logic [N_PORT-1:0] o_port_oe,
   output logic o_expired_flag_n,
   output logic o_sleep_entered_flag_n
);
   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   // a period under two clocks would let the counter match its own clear value,
   // and the held port vector cannot be empty
   initial begin
      if (PERIOD_CYC < 2) begin
         $error("period too short");
      end
      if (N_PORT < 1) begin
         $error("need at least one port bit");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and state
   typedef enum logic [0:0] {RUN, SLEEP} wdslp_state_e;
   wdslp_state_e state_q; // run or sleep
   logic [7:0] opt_q; // timer option control
   logic [7:0] cfg_q; // device configuration word
   logic [31:0] cnt_q; // watchdog base counter
   logic [6:0] scl_q; // shared scaler count
   logic to_n_q; // expired flag, active low
   logic pd_n_q; // power-down flag, active low
   logic rst_q; // device reset pulse
   logic vec_q; // vector request after wake
   logic [15:0] pf_q; // prefetch address
   logic [N_PORT-1:0] pout_q; // held port levels
   logic [N_PORT-1:0] poe_q; // held port enables
   logic ready_q; // apb ready
   logic [31:0] rdata_q; // apb read data
   logic external_reset_pin_n_s1_q, external_reset_pin_n_s2_q; // pin synchroniser

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic acc = i_psel & i_penable & ~ready_q; // one-wait access
   // writes land on the completing edge, where the master samples pready high
   wire logic fin = i_psel & i_penable & ready_q;
   wire logic wr = fin & i_pwrite;
   wire logic hit_opt = (i_paddr == wdslp_pkg::OPT_BYTE);
   wire logic hit_cfg = (i_paddr == wdslp_pkg::CFG_BYTE);
   wire logic hit_ctl = (i_paddr == wdslp_pkg::CTL_BYTE);
   wire logic hit_any = hit_opt | hit_cfg | hit_ctl;
   // core events come either from pins of the core or a control register write
   wire logic kick = i_kick_instruction
      | (wr & hit_ctl & i_pwdata[wdslp_pkg::CTL_KICK]);
   wire logic sleep_req = i_sleep_instruction
      | (wr & hit_ctl & i_pwdata[wdslp_pkg::CTL_SLEEP]);
   wire logic wdt_en = cfg_q[wdslp_pkg::CFG_WATCHDOG_CONFIG_ENABLE];
   wire logic scaler_assign_select = opt_q[wdslp_pkg::OPT_PSA];
   // wake needs the source enable only, global enable is not consulted
   wire logic irq_pend = |(i_wake_irq_flag & i_wake_irq_en);
   // pending interrupt turns sleep into a no-operation
   wire logic sleep_go = sleep_req & (state_q == RUN) & ~irq_pend;
   wire logic clr_wdt = kick | sleep_go;
   wire logic base_end = (cnt_q == 32'(PERIOD_CYC - 1));
   // power-of-two ratio: 2**ps - 1 as the last scaler value
   wire logic [6:0] scl_last = 7'((8'h01 << opt_q[2:0]) - 8'h01);
   wire logic scl_end = ~scaler_assign_select | (scl_q == scl_last);
   wire logic timeout = wdt_en & base_end & scl_end & ~clr_wdt;
   wire logic external_reset_pin_n = ~external_reset_pin_n_s2_q; // pin asserted

   ////////////////////////////////////////////////////////////////////////////
   // external reset pin synchroniser
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         external_reset_pin_n_s1_q <= 1'b1;
         external_reset_pin_n_s2_q <= 1'b1;
      end else begin
         external_reset_pin_n_s1_q <= i_external_reset_pin_n;
         external_reset_pin_n_s2_q <= external_reset_pin_n_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog base counter; counts on the sampled rc tick, modelled per clock
   // clearing on the end value keeps one period exact with or without the scaler
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 32'h0000_0000;
      end else if (!wdt_en || clr_wdt || base_end || external_reset_pin_n) begin
         cnt_q <= 32'h0000_0000;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scaler acts after the counter when assigned; its assignment bit is untouched
   // held at zero while timer0 owns it, so handing it back starts a fresh ratio
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 7'h00;
      end else if (clr_wdt || external_reset_pin_n || !scaler_assign_select) begin
         scl_q <= 7'h00;
      end else if (wdt_en && base_end) begin
         scl_q <= scl_end ? 7'h00 : scl_q + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep state machine and status flags
   // a time-out outranks an interrupt in sleep so the expired flag tells the cause;
   // the pin is checked first because only it may reset the device out of sleep
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= RUN;
         to_n_q <= 1'b1;
         pd_n_q <= 1'b1;
         rst_q <= 1'b0;
         vec_q <= 1'b0;
         pf_q <= 16'h0000;
      end else begin
         rst_q <= 1'b0;
         vec_q <= 1'b0;
         if (external_reset_pin_n) begin
            // only the pin resets out of sleep; flags keep their meaning
            state_q <= RUN;
            rst_q <= 1'b1;
         end else begin
            case (state_q)
               RUN: begin
                  if (timeout) begin
                     rst_q <= 1'b1;
                     to_n_q <= 1'b0;
                  end else if (sleep_go) begin
                     state_q <= SLEEP;
                     to_n_q <= 1'b1;
                     pd_n_q <= 1'b0;
                     pf_q <= i_pc + 16'h0001;
                  end
               end
               SLEEP: begin
                  if (timeout) begin
                     state_q <= RUN;
                     to_n_q <= 1'b0;
                  end else if (irq_pend) begin
                     // arrives during or after entry: wake next cycle
                     state_q <= RUN;
                     vec_q <= i_global_irq_enable;
                  end
               end
               default: state_q <= RUN;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port hold: freeze drive levels while asleep
   // the value latched on the edge before entry is the one held, as the core left it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pout_q <= '0;
         poe_q <= '0;
      end else if (state_q == RUN && !sleep_go) begin
         pout_q <= i_port_out;
         poe_q <= i_port_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, unmapped addresses answer with pslverr
   // read data are captured on the access edge and stand until the next read
   // the control word is write-only for events; its read side shows the two flags
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opt_q <= wdslp_pkg::OPT_RESET;
         cfg_q <= wdslp_pkg::CFG_RESET;
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ready_q <= acc;
         if (wr && hit_opt) begin
            opt_q <= i_pwdata[7:0];
         end
         if (wr && hit_cfg) begin
            cfg_q <= i_pwdata[7:0];
         end
         if (acc && !i_pwrite) begin
            rdata_q <= hit_opt ? {24'h00_0000, opt_q} :
               hit_cfg ? {24'h00_0000, cfg_q} :
               hit_ctl ? {27'h000_0000, to_n_q, pd_n_q, 3'h0} : 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   // each top output is a flop or a constant so the core sees no decode glitches
   logic slverr_q; // error answer
   logic osc_q, rc_q; // oscillator enables
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slverr_q <= 1'b0;
         osc_q <= 1'b1;
         rc_q <= 1'b0;
      end else begin
         slverr_q <= acc & ~hit_any;
         // main oscillator stops in sleep; no clocked peripheral can fire then
         osc_q <= ~(sleep_go | (state_q == SLEEP && !timeout && !irq_pend));
         rc_q <= wdt_en;
      end
   end

   assign o_pready = ready_q;
   assign o_prdata = rdata_q;
   assign o_pslverr = slverr_q;
   assign o_device_reset = rst_q;
   assign o_sleeping = (state_q == SLEEP);
   assign o_main_osc_en = osc_q;
   assign o_rc_osc_en = rc_q;
   assign o_vector_irq = vec_q;
   assign o_prefetch_addr = pf_q;
   assign o_vector_addr = wdslp_pkg::IRQ_VECTOR;
   assign o_port_out = pout_q;
   assign o_port_oe = poe_q;
   assign o_expired_flag_n = to_n_q;
   assign o_sleep_entered_flag_n = pd_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_sleep_taken;
      sleep_go ##1 (state_q == SLEEP);
   endsequence
   timeout_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (timeout && state_q == RUN && !external_reset_pin_n) |=> rst_q) else $error("no reset on time-out");
   timeout_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (timeout && state_q == SLEEP && !external_reset_pin_n) |=> (state_q == RUN && !rst_q))
      else $error("bad wake on time-out");
   expired_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (timeout && !external_reset_pin_n) |=> !to_n_q) else $error("expired flag not cleared");
   wdt_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !wdt_en |=> (cnt_q == 0)) else $error("counter runs while disabled");
   kick_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      kick |=> (cnt_q == 0 && scl_q == 0 && scaler_assign_select == $past(scaler_assign_select)))
      else $error("kick did not clear");
   sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (s_sleep_taken and (!external_reset_pin_n ##1 1)) |-> (!pd_n_q && to_n_q && cnt_q == 0))
      else $error("sleep entry flags wrong");
   sleep_nop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (sleep_req && irq_pend && state_q == RUN && !timeout && !external_reset_pin_n) |=>
      (state_q == RUN && $stable(pd_n_q))) else $error("sleep not a no-op");
   irq_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == SLEEP && irq_pend && !timeout && !external_reset_pin_n) |=>
      (state_q == RUN && vec_q == $past(i_global_irq_enable)))
      else $error("interrupt wake wrong");
   port_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == SLEEP) [*2] |-> $stable(pout_q) && $stable(poe_q))
      else $error("ports moved in sleep");

   // asleep with nothing to wake it
   sequence s_asleep_quiet;
      state_q == SLEEP && !irq_pend && !timeout && !external_reset_pin_n;
   endsequence

   // rc oscillator enable tracks the configuration bit
   rc_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> (rc_q == $past(wdt_en))) else $error("rc oscillator enable wrong");

   // main oscillator is off from the first cycle of sleep
   osc_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (sleep_go && !external_reset_pin_n) |=> !osc_q) else $error("main oscillator still on");

   // no clocked wake in quiet sleep: the oscillator stays off
   osc_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_asleep_quiet |=> !osc_q) else $error("oscillator ran in sleep");

   // prefetch address is the one after the sleep instruction
   prefetch_next_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (sleep_go && !external_reset_pin_n) |=> (pf_q == $past(i_pc) + 16'h0001))
      else $error("prefetch address wrong");

   // the pin always raises the device reset
   pin_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      external_reset_pin_n |=> rst_q) else $error("pin gave no reset");

   // power-down flag only falls on a sleep that took effect
   flag_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(pd_n_q) |-> $past(sleep_go)) else $error("power-down flag fell alone");

   // a masked or absent source leaves the device asleep
   masked_stay_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_asleep_quiet |=> (state_q == SLEEP)) else $error("woke with no source");

   // the scaler steps once per base period until its last value
   scaler_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wdt_en && scaler_assign_select && base_end && !scl_end && !clr_wdt && !external_reset_pin_n) |=>
      (scl_q == $past(scl_q) + 7'h01)) else $error("scaler did not step");

   // a kick never lets a reset through in the same step
   kick_safe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (kick && !external_reset_pin_n) |=> !rst_q) else $error("reset despite kick");

   // a watchdog wake never asks for the interrupt vector
   wake_novec_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (timeout && state_q == SLEEP && !external_reset_pin_n) |=> !vec_q) else $error("vector on watchdog wake");
endmodule : wdslp_top
`default_nettype wire

// ===== logic/wdslp_pkg.sv
// package: register map, field positions and timing for the watchdog and sleep block
package wdslp_pkg;
   // register word indices on the apb slave (printed offsets, not byte addresses)
   localparam logic [15:0] OPT_ADDR = 16'h0081;
   localparam logic [15:0] CFG_ADDR = 16'h2007;
   // printed offsets are not all multiples of four: they are indices, byte address is index*4
   localparam logic [17:0] OPT_BYTE = {OPT_ADDR, 2'b00};
   localparam logic [17:0] CFG_BYTE = {CFG_ADDR, 2'b00};
   localparam logic [17:0] CTL_BYTE = 18'h0_0100; // core-event and status register
   // field positions
   localparam int OPT_PSA = 3;
   localparam int CFG_WATCHDOG_CONFIG_ENABLE = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int CTL_KICK = 0;
   localparam int CTL_SLEEP = 1;
   // reset values
   localparam logic [7:0] OPT_RESET = 8'hff;
   localparam logic [7:0] CFG_RESET = 8'hff;
   // timing: internal rc oscillator and nominal period
   localparam int RC_HZ_X100 = 3125_000; // 31.25 khz times 100
   localparam int PERIOD_MS = 16;
   localparam int CLK_MHZ = 250;
   // 16 ms at 4 ns: 4_000_000 cycles
   localparam int PERIOD_CYC = PERIOD_MS * 1000 * CLK_MHZ;
   // wake-capable interrupt sources
   localparam int N_WAKE = 7;
   // interrupt vector
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;
endpackage : wdslp_pkg

// ===== test/wdslp_core_model.sv
// core-side partner model: instruction pulses, wake sources, pc and port drive
`timescale 1ns/100ps
`default_nettype none
module wdslp_core_model (
   // clock
   input wire logic i_sys_clk,
   // instruction events and core state
   output logic o_kick,
   output logic o_sleep,
   output logic o_gie,
   output logic [15:0] o_pc,
   // wake sources and port drive
   output logic [wdslp_pkg::N_WAKE-1:0] o_flag,
   output logic [wdslp_pkg::N_WAKE-1:0] o_en,
   output logic [15:0] o_port
);
   ////////////////////////////////////////////////////////////////////////////////
   // idle core: no instruction, sources quiet
   initial begin
      o_kick = 1'b0;
      o_sleep = 1'b0;
      o_gie = 1'b0;
      o_pc = 16'h0000;
      o_flag = '0;
      o_en = '0;
      o_port = 16'h0000;
   end
   // one-cycle instruction pulse, dropped at the next edge
   task automatic op(input logic k, input logic s);
      @(posedge i_sys_clk);
      o_kick <= k;
      o_sleep <= s;
      @(posedge i_sys_clk);
      o_kick <= 1'b0;
      o_sleep <= 1'b0;
   endtask : op
   // software habit: kick first so the count surely restarts
   task automatic nap;
      op(1'b1, 1'b0);
      op(1'b0, 1'b1);
   endtask : nap
   // core state and interrupt sources, changed right after an edge
   task automatic drive(input logic g, input logic [15:0] p, input logic [15:0] d,
                        input logic [wdslp_pkg::N_WAKE-1:0] f,
                        input logic [wdslp_pkg::N_WAKE-1:0] e);
      @(posedge i_sys_clk);
      o_gie <= g;
      o_pc <= p;
      o_port <= d;
      o_flag <= f;
      o_en <= e;
   endtask : drive
endmodule : wdslp_core_model
`default_nettype wire

// ===== test/wdslp_top_bench.sv
// self-checking bench for the watchdog and sleep block
`timescale 1ns/100ps
`default_nettype none
module wdslp_top_bench;
   localparam int P = 20; // shortened period keeps the run short
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic pin_n = 1'b1;
   logic [17:0] paddr = 18'h0_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic kick, slp, global_irq_enable, pready, perr, drst, sleeping, mosc, rosc, virq, to_n, pd_n, er;
   logic [15:0] pc, port, pfa, port_q, oe_q, vaddr;
   logic [wdslp_pkg::N_WAKE-1:0] flag, en;
   logic [31:0] prdata, rd;
   int mismatches = 0;
   int n_checks = 0;
   int n;
   always #2 i_sys_clk = ~i_sys_clk;
   wdslp_core_model core (.i_sys_clk(i_sys_clk), .o_kick(kick), .o_sleep(slp), .o_gie(global_irq_enable),
      .o_pc(pc), .o_flag(flag), .o_en(en), .o_port(port));
   wdslp_top #(.PERIOD_CYC(P)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(perr), .i_external_reset_pin_n(pin_n),
      .i_kick_instruction(kick), .i_sleep_instruction(slp), .i_global_irq_enable(global_irq_enable),
      .i_pc(pc), .i_wake_irq_flag(flag), .i_wake_irq_en(en), .i_port_out(port),
      .i_port_oe(~port), .o_device_reset(drst), .o_sleeping(sleeping), .o_main_osc_en(mosc),
      .o_rc_osc_en(rosc), .o_vector_irq(virq), .o_prefetch_addr(pfa), .o_vector_addr(vaddr),
      .o_port_out(port_q), .o_port_oe(oe_q), .o_expired_flag_n(to_n),
      .o_sleep_entered_flag_n(pd_n));
   ////////////////////////////////////////////////////////////////////////////////
   // comparison and verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   // a wait that ran out is a failure of its own
   task automatic hang;
      mismatches++;
      complete_run();
   endtask : hang
   ////////////////////////////////////////////////////////////////////////////////
   // apb master: hold the request until pready is sampled high
   task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      int i;
      @(posedge i_sys_clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      pen <= 1'b1;
      for (i = 0; i < 16 && pready !== 1'b1; i++)
         @(posedge i_sys_clk);
      if (i == 16)
         hang();
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [17:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask : rdc
   // cycles until the device reset pulse, left in n
   task automatic wait_rst(input int lim);
      for (n = 1; n <= lim; n++) begin
         @(posedge i_sys_clk);
         #1;
         if (drst === 1'b1)
            return;
      end
      hang();
   endtask : wait_rst
   // no device reset may appear for cyc cycles
   task automatic quiet(input int cyc, input string nm);
      int c;
      c = 0;
      repeat (cyc) begin
         @(posedge i_sys_clk);
         #1;
         if (drst !== 1'b0)
            c++;
      end
      chk(nm, 0, c);
   endtask : quiet
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs;
      rdc(wdslp_pkg::OPT_BYTE, 32'h0000_00ff, "option");
      rdc(wdslp_pkg::CFG_BYTE, 32'h0000_00ff, "config");
      rdc(wdslp_pkg::CTL_BYTE, 32'h0000_0018, "status");
      chk("rc osc on", 1'b1, rosc);
      rdc(18'h0_3000, 32'h0000_0000, "unmapped");
      chk("slverr", 1'b1, er);
   endtask : t_regs
   // pending enabled irq turns sleep into a no-operation
   task automatic t_pend;
      core.drive(1'b0, 16'h0010, 16'h0000, 7'h01, 7'h01);
      core.op(1'b0, 1'b1);
      #1;
      chk("no sleep", 1'b0, sleeping);
      chk("pd kept", 1'b1, pd_n);
      chk("to kept", 1'b1, to_n);
      core.drive(1'b0, 16'h0010, 16'h0000, 7'h00, 7'h00);
   endtask : t_pend
   task automatic t_run;
      apb(1'b1, wdslp_pkg::OPT_BYTE, 32'h0000_0000);
      repeat (4) begin
         core.op(1'b1, 1'b0);
         quiet(P - 4, "kicked reset");
      end
      core.op(1'b1, 1'b0);
      wait_rst(P + 8);
      chk("period", 1'b1, n >= P - 2 && n <= P + 2);
      chk("to cleared", 1'b0, to_n);
   endtask : t_run
   task automatic t_scal;
      for (int r = 0; r < 3; r++) begin
         apb(1'b1, wdslp_pkg::OPT_BYTE, 32'h0000_0008 | r);
         core.op(1'b1, 1'b0);
         wait_rst(P * 16);
         chk("scaled period", 1'b1, n >= (P << r) - 2 && n <= (P << r) + 2);
         rdc(wdslp_pkg::OPT_BYTE, 32'h0000_0008 | r, "assign kept");
      end
   endtask : t_scal
   task automatic t_sleep;
      apb(1'b1, wdslp_pkg::OPT_BYTE, 32'h0000_0000);
      core.drive(1'b0, 16'h0123, 16'ha5a5, 7'h00, 7'h00);
      core.nap();
      #1;
      chk("sleeping", 1'b1, sleeping);
      chk("pd cleared", 1'b0, pd_n);
      chk("to set", 1'b1, to_n);
      chk("main osc", 1'b0, mosc);
      chk("prefetch", 16'h0124, pfa);
      core.drive(1'b0, 16'h0124, 16'h5a5a, 7'h00, 7'h00);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk("held port", 16'ha5a5, port_q);
      chk("held oe", 16'h5a5a, oe_q);
      for (n = 0; n < 4 * P && sleeping === 1'b1; n++) begin
         @(posedge i_sys_clk);
         #1;
         chk("reset in sleep", 1'b0, drst);
      end
      chk("wdt wake", 1'b0, sleeping);
      chk("to on wake", 1'b0, to_n);
      chk("main osc back", 1'b1, mosc);
   endtask : t_sleep
   // every wake source, masked then enabled, with and without global enable
   task automatic t_irq;
      for (int g = 0; g < 2; g++) begin
         for (int s = 0; s < wdslp_pkg::N_WAKE; s++) begin
            core.nap();
            core.drive(g[0], 16'h0200, 16'h0000, 7'h01 << s, 7'h00);
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk("masked wake", 1'b1, sleeping);
            core.drive(g[0], 16'h0200, 16'h0000, 7'h01 << s, 7'h01 << s);
            @(posedge i_sys_clk);
            #1;
            chk("irq wake", 1'b0, sleeping);
            chk("vector", g[0], virq);
            chk("pd after wake", 1'b0, pd_n);
            core.drive(1'b0, 16'h0200, 16'h0000, 7'h00, 7'h00);
         end
      end
      chk("vector addr", 16'h0004, vaddr);
   endtask : t_irq
   task automatic t_pin;
      core.nap();
      @(posedge i_sys_clk);
      pin_n <= 1'b0;
      wait_rst(6);
      chk("pin wake", 1'b0, sleeping);
      chk("pd on pin", 1'b0, pd_n);
      @(posedge i_sys_clk);
      pin_n <= 1'b1;
   endtask : t_pin
   task automatic t_off;
      apb(1'b1, wdslp_pkg::CFG_BYTE, 32'h0000_00fb);
      core.op(1'b1, 1'b0);
      #1;
      chk("rc osc off", 1'b0, rosc);
      quiet(3 * P, "disabled reset");
   endtask : t_off
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset, then every scenario
   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_pend();
      t_run();
      t_scal();
      t_sleep();
      t_irq();
      t_pin();
      t_off();
      complete_run();
   end
endmodule : wdslp_top_bench
`default_nettype wire
